// >>> logic/ppm_pkg.sv
package ppm_pkg;
  // ****************************************************
  // Pin function selects
  // ****************************************************
  typedef enum logic [1:0] {
    PPM_FN_PORT = 2'b00,
    PPM_FN_ALT1 = 2'b01,
    PPM_FN_ALT2 = 2'b10,
    PPM_FN_ALT3 = 2'b11
  } ppm_fn_e;

  // Pin order in all vectors
  localparam int PPM_NPINS = 6;
  localparam int PPM_A10 = 0;
  localparam int PPM_A11 = 1;
  localparam int PPM_B0 = 2;
  localparam int PPM_B1 = 3;
  localparam int PPM_B2 = 4;
  localparam int PPM_B3 = 5;
  localparam logic [5:0] PPM_RST_OE = 6'h00;
  localparam logic [5:0] PPM_RST_PU = 6'h3f;

  // Per-pin drive bundle
  typedef struct packed {
    logic [5:0] dout;
    logic [5:0] oe;
    logic [5:0] pu;
  } ppm_pad_s;

  // Serial interface view
  typedef struct packed {
    logic master;
    logic clk_out;
    logic sel_out;
    logic to_master_out;
    logic to_slave_out;
  } ppm_serial_s;
endpackage : ppm_pkg

// >>> logic/ppm_port_pin_function_mux.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_port_pin_function_mux (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // Function selects from the system integration unit
  input wire logic [11:0] i_fn_sel,
  // Port function: per-pin direction and data
  input wire logic [5:0] i_port_dir,
  input wire logic [5:0] i_port_dout,
  output logic [5:0] o_port_din,
  // Serial interface
  input wire ppm_pkg::ppm_serial_s i_serial,
  output logic o_serial_clk_in,
  output logic o_serial_sel_n_in,
  output logic o_serial_to_master_in,
  output logic o_serial_to_slave_in,
  // Two-wire bus
  input wire logic i_tw_clk_oe,
  input wire logic i_tw_data_oe,
  output logic o_tw_clk_in,
  output logic o_tw_data_in,
  // Timer channels
  input wire logic [1:0] i_timer_out,
  input wire logic [1:0] i_timer_oe,
  output logic [1:0] o_timer_in,
  // PWM external sources and comparator enables
  output logic [1:0] o_ext_pwm_src,
  output logic [1:0] o_comp_in2_en,
  // Pads
  input wire logic [5:0] i_pad_in,
  output logic [5:0] o_pad_out,
  output logic [5:0] o_pad_oe,
  output logic [5:0] o_pad_pu
);
  // ****************************************************
  // Reset release
  // ****************************************************
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  function automatic ppm_pkg::ppm_fn_e fn_of(input logic [11:0] s,
                                             input int p);
    fn_of = ppm_pkg::ppm_fn_e'(s[2*p +: 2]);
  endfunction : fn_of

  // ****************************************************
  // Routing
  // ****************************************************
  ppm_pkg::ppm_pad_s pad_d, pad_q;
  logic [5:0] din_d, din_q;
  logic [9:0] per_d, per_q;
  logic sel_n;
  always_comb begin
    pad_d.dout = i_port_dout;
    pad_d.oe = i_port_dir;
    pad_d.pu = ~i_port_dir;
    din_d = i_pad_in;
    // Idle levels when unrouted: clocks high, select inactive
    per_d = 10'h0a7;
    sel_n = 1'b1;
    for (int p = ppm_pkg::PPM_A10; p <= ppm_pkg::PPM_A11; p++) begin
      if (fn_of(i_fn_sel, p) != ppm_pkg::PPM_FN_PORT) begin
        pad_d.oe[p] = 1'b0;
        pad_d.pu[p] = 1'b0;
        per_d[8 + p] = 1'b1;
      end
    end
    case (fn_of(i_fn_sel, ppm_pkg::PPM_B0))
      ppm_pkg::PPM_FN_ALT1: begin
        pad_d.dout[2] = i_serial.clk_out;
        pad_d.oe[2] = i_serial.master;
        per_d[0] = i_pad_in[2];
      end
      ppm_pkg::PPM_FN_ALT2: begin
        pad_d.dout[2] = 1'b0;
        pad_d.oe[2] = i_tw_clk_oe;
        per_d[5] = i_pad_in[2];
      end
      default: ;
    endcase
    case (fn_of(i_fn_sel, ppm_pkg::PPM_B1))
      ppm_pkg::PPM_FN_ALT1: begin
        pad_d.dout[3] = i_serial.sel_out;
        pad_d.oe[3] = i_serial.master;
        sel_n = i_serial.master | i_pad_in[3];
        per_d[1] = sel_n;
      end
      ppm_pkg::PPM_FN_ALT2: begin
        pad_d.dout[3] = 1'b0;
        pad_d.oe[3] = i_tw_data_oe;
        per_d[7] = i_pad_in[3];
      end
      default: ;
    endcase
    // Slave data from the interface, retimed through pad_q on i_sys_clk like every pad output
    case (fn_of(i_fn_sel, ppm_pkg::PPM_B2))
      ppm_pkg::PPM_FN_ALT1: begin
        pad_d.dout[4] = i_serial.to_master_out;
        pad_d.oe[4] = !i_serial.master && !sel_n;
        per_d[2] = i_pad_in[4];
      end
      ppm_pkg::PPM_FN_ALT2: begin
        pad_d.dout[4] = i_timer_out[0];
        pad_d.oe[4] = i_timer_oe[0];
        per_d[4] = i_pad_in[4];
      end
      ppm_pkg::PPM_FN_ALT3: begin
        pad_d.oe[4] = 1'b0;
        per_d[6] = i_pad_in[4];
      end
      default: ;
    endcase
    case (fn_of(i_fn_sel, ppm_pkg::PPM_B3))
      ppm_pkg::PPM_FN_ALT1: begin
        pad_d.dout[5] = i_serial.to_slave_out;
        pad_d.oe[5] = i_serial.master;
        per_d[3] = i_pad_in[5];
      end
      ppm_pkg::PPM_FN_ALT2: begin
        pad_d.dout[5] = i_timer_out[1];
        pad_d.oe[5] = i_timer_oe[1];
      end
      ppm_pkg::PPM_FN_ALT3: begin
        pad_d.oe[5] = 1'b0;
      end
      default: ;
    endcase
    // Any alternate function isolates the port input
    for (int p = 0; p < ppm_pkg::PPM_NPINS; p++) begin
      if (fn_of(i_fn_sel, p) != ppm_pkg::PPM_FN_PORT) begin
        din_d[p] = 1'b0;
      end
    end
  end

  // B3 timer and PWM source inputs kept apart from per_q so comparator enables own bits 9:8
  logic src1_d, src1_q;
  logic tin1_d, tin1_q;
  always_comb begin
    src1_d = (fn_of(i_fn_sel, ppm_pkg::PPM_B3) == ppm_pkg::PPM_FN_ALT3)
             && i_pad_in[5];
    tin1_d = (fn_of(i_fn_sel, ppm_pkg::PPM_B3) == ppm_pkg::PPM_FN_ALT2)
             && i_pad_in[5];
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pad_q.dout <= 6'h00;
      pad_q.oe <= ppm_pkg::PPM_RST_OE;
      pad_q.pu <= ppm_pkg::PPM_RST_PU;
      din_q <= 6'h00;
      per_q <= 10'h0a7;
      src1_q <= 1'b0;
      tin1_q <= 1'b0;
    end else if (!rst_n_q) begin
      pad_q.dout <= 6'h00;
      pad_q.oe <= ppm_pkg::PPM_RST_OE;
      pad_q.pu <= ppm_pkg::PPM_RST_PU;
      din_q <= 6'h00;
      per_q <= 10'h0a7;
      src1_q <= 1'b0;
      tin1_q <= 1'b0;
    end else begin
      pad_q <= pad_d;
      din_q <= din_d;
      per_q <= per_d;
      src1_q <= src1_d;
      tin1_q <= tin1_d;
    end
  end

  assign o_pad_out = pad_q.dout;
  assign o_pad_oe = pad_q.oe;
  assign o_pad_pu = pad_q.pu;
  assign o_port_din = din_q;
  assign o_serial_clk_in = per_q[0];
  assign o_serial_sel_n_in = per_q[1];
  assign o_serial_to_master_in = per_q[2];
  assign o_serial_to_slave_in = per_q[3];
  assign o_timer_in = {tin1_q, per_q[4]};
  assign o_tw_clk_in = per_q[5];
  assign o_tw_data_in = per_q[7];
  assign o_ext_pwm_src = {src1_q, per_q[6]};
  assign o_comp_in2_en = per_q[9:8];

  // ****************************************************
  // Checks
  // ****************************************************
  AST_RESET_PORT: assert property (@(posedge i_sys_clk)
    !rst_n_q |=> (o_pad_oe == 6'h00 && o_pad_pu == 6'h3f))
    else $error("Pads not idle during reset");
  AST_CMP_A_UNDRIVEN: assert property (@(posedge i_sys_clk)
    disable iff (!rst_n_q)
    fn_of(i_fn_sel, 0) != ppm_pkg::PPM_FN_PORT |=> !o_pad_oe[0])
    else $error("A10 driven in analog mode");
  AST_CMP_B_UNDRIVEN: assert property (@(posedge i_sys_clk)
    disable iff (!rst_n_q)
    fn_of(i_fn_sel, 1) != ppm_pkg::PPM_FN_PORT |=> !o_pad_oe[1])
    else $error("A11 driven in analog mode");
  AST_PORT_DIR: assert property (@(posedge i_sys_clk)
    disable iff (!rst_n_q)
    fn_of(i_fn_sel, 2) == ppm_pkg::PPM_FN_PORT |=>
      o_pad_oe[2] == $past(i_port_dir[2]))
    else $error("B0 direction not followed");
  AST_CLK_DIR: assert property (@(posedge i_sys_clk)
    disable iff (!rst_n_q)
    fn_of(i_fn_sel, 2) == ppm_pkg::PPM_FN_ALT1 |=>
      o_pad_oe[2] == $past(i_serial.master))
    else $error("Serial clock direction wrong");
  AST_MISO_DIR: assert property (@(posedge i_sys_clk)
    disable iff (!rst_n_q)
    fn_of(i_fn_sel, 4) == ppm_pkg::PPM_FN_ALT1 && i_serial.master
      |=> !o_pad_oe[4])
    else $error("Master drives data-to-master");
  AST_MISO_RELEASE: assert property (@(posedge i_sys_clk)
    disable iff (!rst_n_q)
    fn_of(i_fn_sel, 4) == ppm_pkg::PPM_FN_ALT1 && sel_n |=> !o_pad_oe[4])
    else $error("Unselected slave drives line");
  AST_MOSI_DIR: assert property (@(posedge i_sys_clk)
    disable iff (!rst_n_q)
    fn_of(i_fn_sel, 5) == ppm_pkg::PPM_FN_ALT1 |=>
      o_pad_oe[5] == $past(i_serial.master))
    else $error("Data-to-slave direction wrong");
  AST_PWM_SRC0: assert property (@(posedge i_sys_clk)
    disable iff (!rst_n_q)
    fn_of(i_fn_sel, 4) == ppm_pkg::PPM_FN_ALT3 |=>
      o_ext_pwm_src[0] == $past(i_pad_in[4]) && !o_pad_oe[4])
    else $error("Pwm source 0 not routed");
endmodule : ppm_port_pin_function_mux
`default_nettype wire

// >>> tb/ppm_pad_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_pad_partner (
  // Block pads
  input wire logic [5:0] i_pad_out,
  input wire logic [5:0] i_pad_oe,
  input wire logic [5:0] i_pad_pu,
  // Far-side drivers
  input wire logic [5:0] i_ext_val,
  input wire logic [5:0] i_ext_oe,
  output logic [5:0] o_level
);
  logic tog = 1'b0;
  // Floating line toggles so no stale level passes
  always #2.5 tog = ~tog;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (i_pad_oe[i])
        o_level[i] = i_pad_out[i];
      else if (i_ext_oe[i])
        o_level[i] = i_ext_val[i];
      else
        o_level[i] = i_pad_pu[i] | tog;
    end
  end
endmodule : ppm_pad_partner
`default_nettype wire

// >>> tb/test_port_pin_function_mux.sv
`timescale 1ns/1ps
`default_nettype none
module test_port_pin_function_mux;
  typedef struct packed {logic [23:0] v; logic [23:0] m;} ppm_note_s;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [11:0] fn = 12'h000;
  logic [5:0] dir = 6'h00, dout = 6'h00, ev = 6'h3f;
  logic [5:0] pad_in, poe, pout, ppu, din;
  logic tco = 1'b0, tdo = 1'b0;
  logic [1:0] tmo = 2'b00, tmoe = 2'b00;
  ppm_pkg::ppm_serial_s ser = '0;
  logic ci, si, mi, oi, twc, twd;
  logic [1:0] tin, pwm, comp;
  logic [23:0] obs;
  logic [31:0] rs = 32'h9170, r;
  ppm_note_s q[$];
  ppm_note_s n;
  int fail_count = 0;
  int checked = 0;
  assign obs = {poe, pout & poe, comp, pwm, ci, si, mi, oi, twc, twd, tin};
  initial begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  ppm_port_pin_function_mux u_dut (.i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n), .i_fn_sel(fn), .i_port_dir(dir),
    .i_port_dout(dout), .o_port_din(din), .i_serial(ser),
    .o_serial_clk_in(ci), .o_serial_sel_n_in(si),
    .o_serial_to_master_in(mi), .o_serial_to_slave_in(oi),
    .i_tw_clk_oe(tco), .i_tw_data_oe(tdo), .o_tw_clk_in(twc),
    .o_tw_data_in(twd), .i_timer_out(tmo), .i_timer_oe(tmoe),
    .o_timer_in(tin), .o_ext_pwm_src(pwm), .o_comp_in2_en(comp),
    .i_pad_in(pad_in), .o_pad_out(pout), .o_pad_oe(poe), .o_pad_pu(ppu));
  ppm_pad_partner u_pad (.i_pad_out(pout), .i_pad_oe(poe), .i_pad_pu(ppu),
    .i_ext_val(ev), .i_ext_oe(6'h3f), .o_level(pad_in));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  task automatic check(string nm, logic [23:0] seen, logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Settle three cycles so the input path is through
  task automatic note(logic [23:0] v, logic [23:0] m);
    repeat (3) @(negedge i_sys_clk);
    q.push_back('{v, m});
    @(negedge i_sys_clk);
  endtask : note
  task automatic finish_test();
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  always @(posedge i_sys_clk) begin
    #1;
    if (q.size() > 0) begin
      n = q.pop_front();
      check("outputs", obs & n.m, n.v & n.m);
    end
  end
  // ****************************
  // Scenarios
  // ****************************
  initial begin
    repeat (2) @(negedge i_sys_clk);
    check("reset", {12'h000, poe, ppu}, {18'h0, 6'h3f});
    repeat (2) @(negedge i_sys_clk);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    note({12'h000, 12'h0ec}, '1);
    for (int i = 0; i < 6; i++) begin
      r = xs();
      dir = r[5:0];
      dout = r[11:6];
      ev = r[17:12];
      note({dir, dout & dir, 12'h0ec}, '1);
      check("port din pu", {12'h0, din, ppu},
        {12'h0, (dout & dir) | (ev & ~dir), ~dir});
    end
    $display("test port done");
    fn = 12'h009;
    dir = 6'h3f;
    note({6'h3c, dout & 6'h3c, 2'b11, 10'h0ec}, '1);
    check("comp din", {18'h0, din}, {18'h0, dout & 6'h3c});
    dir = 6'h00;
    $display("test comparator done");
    fn = 12'h510;
    ser.master = 1'b1;
    for (int i = 0; i < 8; i++) begin
      ser.clk_out = i[0];
      ser.to_slave_out = i[1];
      ev[4] = i[2];
      note({6'h24, i[1], 2'b00, i[0], 6'h0, 2'b00, i[2], 5'b01100},
        24'hffff2f);
    end
    $display("test master done");
    fn = 12'h550;
    ser.master = 1'b0;
    for (int i = 0; i < 8; i++) begin
      ser.to_master_out = i[2];
      ev = {i[1], 2'b10, i[0], 2'b11};
      note({6'h10, 1'b0, i[2], 8'h0, i[0], 2'b00, i[1], 4'b1100},
        24'hffffdf);
    end
    ev[3] = 1'b1;
    note({16'h0000, 8'hdc}, 24'hffffdf);
    $display("test slave done");
    fn = 12'ha00;
    for (int i = 0; i < 4; i++) begin
      r = xs();
      tmo = r[1:0];
      tmoe = r[3:2];
      ev[5:4] = r[5:4];
      note({tmoe, 4'h0, tmo & tmoe, 8'h0, 6'b111011,
        (tmoe & tmo) | (~tmoe & r[5:4])}, '1);
    end
    $display("test timer done");
    fn = 12'hf00;
    for (int i = 0; i < 4; i++) begin
      ev[5:4] = i[1:0];
      note({14'h0, i[1:0], 6'b111011, 2'b00}, '1);
    end
    $display("test pwm source done");
    fn = 12'h0a0;
    ev = 6'h3f;
    for (int i = 0; i < 4; i++) begin
      tco = i[0];
      tdo = i[1];
      note({2'b00, i[1], i[0], 12'h0, 4'b1110, ~i[0], ~i[1], 2'b00},
        '1);
    end
    $display("test two-wire done");
    for (int k = 0; k < 20 && q.size() > 0; k++)
      @(posedge i_sys_clk);
    if (q.size() != 0)
      fail_count++;
    finish_test();
  end
endmodule : test_port_pin_function_mux
`default_nettype wire
